// file: hdl/adc_link_pkg.sv
/*
  Shared constants and types for the dual-result serial readout link.
  Assumes both ends and the bench compile it first.
*/
package adc_link_pkg;
  localparam int RESULT_BITS  = 12;
  localparam int LEAD_ZEROS   = 2;
  localparam int SLOT_LEN     = 16;
  localparam int SHORT_FRAME  = 14;
  localparam int TRACK_EDGE   = 13;
  localparam int DUAL_END     = 32;
  localparam int PD_FIRST     = 2;
  localparam int PD_LAST      = 10;
  localparam int PD_FRAME     = 8;
  localparam int CNT_BITS     = 6;
  localparam int WORD_BITS    = 32;
  // host side: link clock from the system clock
  localparam int SYS_CLK_MHZ  = 100;
  localparam int SCLK_HALF    = 4;
  localparam int PHASE_BITS   = 3;
  localparam int CAPTURE_PH   = 2;
  localparam int QUIET_NS     = 50;
  localparam int QUIET_CYC    = (QUIET_NS * SYS_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PARTIAL,
    MODE_FULL
  } power_mode_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_RUN,
    HOST_QUIET
  } host_state_t;
endpackage

// file: hdl/adc_link_if.sv
/*
  Link wires between the converter end and the host end.
  Result lines read low when nobody drives them.
*/
`timescale 1ns/1ns
interface adc_link_if;
  logic select_b;
  logic sclk;
  logic result_line_a_out;
  logic result_line_a_oe;
  logic result_line_b_out;
  logic result_line_b_oe;
  logic result_line_a;
  logic result_line_b;

  assign result_line_a = result_line_a_oe ? result_line_a_out : 1'b0;
  assign result_line_b = result_line_b_oe ? result_line_b_out : 1'b0;

  modport device (
    input  select_b,
    input  sclk,
    output result_line_a_out,
    output result_line_a_oe,
    output result_line_b_out,
    output result_line_b_oe
  );

  modport host (
    output select_b,
    output sclk,
    input  result_line_a,
    input  result_line_b
  );
endinterface

// file: hdl/adc_dual_readout_dev.sv
/*
  Converter end of the link: sample on select fall, shift two aligned
  results on the link clock falling edges, track power-down modes.
  Assumes the host drives select and the link clock; sample inputs
  stand for the analog values and are steady around select fall.
*/
// Functional notes
// R1: select fall holds, samples, drives lines
// R2: conversion needs fourteen link clocks
// R3: track again after thirteenth falling edge
// R4: sixteen-clock frame ends with two zeros
// R5: select rise aborts, releases both lines
// R6: longer low select chains other result
// R7: release lines at fall 32 or rise
// R8: two leading zeros start each result
// R9: twelve bits msb first, one per fall
// R10: host may capture on rising edges
// R11: early rising edge changes nothing
// R12: fall coincident with select not counted
// R13: eight-clock frame commands power-down
// R14: host frames 16 or 14 bit words
// R15: host starts frames on whole periods
// R16: rise in edges 2..9 powers down
// R17: second such rise gives full power-down
// R18: long dummy frame powers up, data invalid
// R19: both lines shift on same edges
`timescale 1ns/1ns
module adc_dual_readout_dev (
  adc_link_if.device                   link,
  input  wire logic                    rst_b,
  input  wire logic [11:0]             sample_a,
  input  wire logic [11:0]             sample_b,
  output      logic                    hold,
  output      adc_link_pkg::power_mode_t power_mode
);
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [11:0] value_a;
  logic [11:0] value_b;
  logic        tracked;
  logic        ended;
  logic        out_a;
  logic        out_b;

  // bit shown after n counted falling edges
  function automatic logic bit_at(input logic [5:0]  n,
                                  input logic [11:0] first,
                                  input logic [11:0] second);
    logic [5:0]  m;
    logic [11:0] slot;
    logic        b;
    m    = n;
    slot = first;
    b    = 1'b0;
    if (n >= 6'(adc_link_pkg::SLOT_LEN)) begin // see R6
      m    = 6'(n - 6'(adc_link_pkg::SLOT_LEN));
      slot = second;
    end
    // zeros before and after the result field
    if (m >= 6'(adc_link_pkg::LEAD_ZEROS) &&
        m < 6'(adc_link_pkg::LEAD_ZEROS + adc_link_pkg::RESULT_BITS)) begin
      b = slot[4'(adc_link_pkg::LEAD_ZEROS +
                  adc_link_pkg::RESULT_BITS - 1 - 32'(m))]; // see R9 R8 R4
    end
    return b;
  endfunction

  assign next_cnt = (cnt < 6'(adc_link_pkg::DUAL_END)) ?
                    6'(cnt + 6'h01) : cnt;

  // sample both inputs at select fall; dummy frame result is zeros
  always_ff @(negedge link.select_b or negedge rst_b) begin
    if (!rst_b) begin
      value_a <= 12'h000;
      value_b <= 12'h000;
    end else if (power_mode == adc_link_pkg::MODE_NORMAL) begin
      value_a <= sample_a; // see R1
      value_b <= sample_b;
    end else begin
      value_a <= 12'h000; // see R18
      value_b <= 12'h000;
    end
  end

  // falling edge count and shifted bits, cleared while select is high
  always_ff @(negedge link.sclk or posedge link.select_b or
              negedge rst_b) begin
    if (!rst_b) begin
      cnt   <= 6'h00;
      out_a <= 1'b0;
      out_b <= 1'b0;
      ended <= 1'b0;
    end else if (link.select_b) begin
      cnt   <= 6'h00; // see R5 R12
      out_a <= 1'b0;
      out_b <= 1'b0;
      ended <= 1'b0;
    end else begin
      cnt   <= next_cnt; // see R2
      out_a <= bit_at(next_cnt, value_a, value_b); // see R19
      out_b <= bit_at(next_cnt, value_b, value_a);
      if (next_cnt >= 6'(adc_link_pkg::DUAL_END)) begin
        ended <= 1'b1; // see R7
      end
    end
  end

  // back to track on the rising edge after the thirteenth fall
  always_ff @(posedge link.sclk or posedge link.select_b or
              negedge rst_b) begin
    if (!rst_b) begin
      tracked <= 1'b0;
    end else if (link.select_b) begin
      tracked <= 1'b0;
    end else if (cnt >= 6'(adc_link_pkg::TRACK_EDGE)) begin
      tracked <= 1'b1; // see R3 R11
    end
  end

  // mode change judged on the count standing at select rise
  always_ff @(posedge link.select_b or negedge rst_b) begin
    if (!rst_b) begin
      power_mode <= adc_link_pkg::MODE_NORMAL;
    end else if (cnt >= 6'(adc_link_pkg::PD_LAST)) begin
      power_mode <= adc_link_pkg::MODE_NORMAL; // see R18
    end else if (cnt >= 6'(adc_link_pkg::PD_FIRST)) begin
      if (power_mode == adc_link_pkg::MODE_NORMAL) begin
        power_mode <= adc_link_pkg::MODE_PARTIAL; // see R16
      end else begin
        power_mode <= adc_link_pkg::MODE_FULL; // see R17
      end
    end
  end

  assign hold = !link.select_b && !tracked; // see R1 R3
  assign link.result_line_a_out = out_a;
  assign link.result_line_b_out = out_b;
  assign link.result_line_a_oe  = !link.select_b && !ended; // see R1 R5 R7
  assign link.result_line_b_oe  = !link.select_b && !ended;
endmodule

// file: hdl/adc_readout_host.sv
/*
  Host end of the link: makes select and the link clock from sys_clk,
  clocks out a frame of the requested length (32 when it is 0 or above 32), captures both lines.
  Assumes the converter end sits on the other side of the interface.
*/
`timescale 1ns/1ns
module adc_readout_host (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 req_valid,
  output      logic                 req_ready,
  input  wire logic [5:0]           host_word_length,
  output      logic                 resp_valid,
  output      logic [31:0]          word_a,
  output      logic [31:0]          word_b,
  adc_link_if.host                  link
);
  adc_link_pkg::host_state_t state;
  logic [2:0] ph;
  logic [2:0] next_ph;
  logic [5:0] falls;
  logic [5:0] target;
  logic [2:0] quiet;
  logic       done;
  logic       sel_b;
  logic       sclk_q;
  logic       a_s1;
  logic       a_s2;
  logic       b_s1;
  logic       b_s2;

  assign req_ready = (state == adc_link_pkg::HOST_IDLE);
  assign next_ph   = 3'(ph + 3'h1);
  assign done      = (state == adc_link_pkg::HOST_RUN) &&
                     (ph == 3'(adc_link_pkg::CAPTURE_PH)) &&
                     (falls == target);

  // frame sequencing; frames always start on a clock phase boundary
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state  <= adc_link_pkg::HOST_IDLE;
      ph     <= 3'h0;
      falls  <= 6'h00;
      target <= 6'h00;
      quiet  <= 3'h0;
    end else begin
      unique case (state)
        adc_link_pkg::HOST_IDLE: begin
          if (req_valid) begin
            state <= adc_link_pkg::HOST_RUN; // see R15
            ph    <= 3'h0;
            falls <= 6'h00;
            // lengths 1..32; 8 commands power-down, 14 or 16 one word
            if (host_word_length == 6'h00 ||
                host_word_length > 6'(adc_link_pkg::DUAL_END)) begin
              target <= 6'(adc_link_pkg::DUAL_END); // see R14 R13 R2
            end else begin
              target <= host_word_length;
            end
          end
        end
        adc_link_pkg::HOST_RUN: begin
          ph <= next_ph;
          if (next_ph == 3'(adc_link_pkg::SCLK_HALF)) begin
            falls <= 6'(falls + 6'h01);
          end
          if (done) begin
            state <= adc_link_pkg::HOST_QUIET;
            quiet <= 3'h0;
          end
        end
        adc_link_pkg::HOST_QUIET: begin
          quiet <= 3'(quiet + 3'h1);
          if (quiet == 3'(adc_link_pkg::QUIET_CYC - 1)) begin
            state <= adc_link_pkg::HOST_IDLE;
          end
        end
        default: begin
          state <= adc_link_pkg::HOST_IDLE;
        end
      endcase
    end
  end

  // link pins from flops; clock idles high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_b  <= 1'b1;
      sclk_q <= 1'b1;
    end else if (state == adc_link_pkg::HOST_IDLE) begin
      sel_b  <= !req_valid;
      sclk_q <= 1'b1;
    end else if (state == adc_link_pkg::HOST_RUN && !done) begin
      sel_b  <= 1'b0;
      sclk_q <= (next_ph < 3'(adc_link_pkg::SCLK_HALF));
    end else begin
      sel_b  <= 1'b1;
      sclk_q <= 1'b1;
    end
  end

  // result lines into the system clock domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
    end else begin
      a_s1 <= link.result_line_a;
      a_s2 <= a_s1;
      b_s1 <= link.result_line_b;
      b_s2 <= b_s1;
    end
  end

  // take the bit standing at each rising edge after a fall
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_a     <= 32'h0000_0000;
      word_b     <= 32'h0000_0000;
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= done;
      if (state == adc_link_pkg::HOST_IDLE && req_valid) begin
        word_a <= 32'h0000_0000;
        word_b <= 32'h0000_0000;
      end else if (state == adc_link_pkg::HOST_RUN &&
                   ph == 3'(adc_link_pkg::CAPTURE_PH) &&
                   falls != 6'h00) begin
        word_a <= {word_a[30:0], a_s2}; // see R10
        word_b <= {word_b[30:0], b_s2};
      end
    end
  end

  assign link.select_b = sel_b;
  assign link.sclk     = sclk_q;
endmodule

// file: bench/adc_link_asserts.sv
/* Link wire checker: frame start, zeros, drive enables.
   Assumes the bench wires it to the link interface. */
`timescale 1ns/1ns
module adc_link_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic select_b,
  input wire logic sclk,
  input wire logic result_line_a_oe,
  input wire logic result_line_b_oe,
  input wire logic result_line_a,
  input wire logic result_line_b
);
  logic [5:0] falls;
  // link clock falls seen in this frame
  always_ff @(negedge sclk or posedge select_b or negedge rst_b) begin
    if (!rst_b) falls <= 6'h00;
    else if (select_b) falls <= 6'h00;
    else if (falls != 6'h20) falls <= falls + 6'h01;
  end
  chk_start_drive:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      $fell(select_b) |-> result_line_a_oe && result_line_b_oe)
    else $error("lines idle at frame start");
  chk_idle_release:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      select_b |-> !result_line_a_oe && !result_line_b_oe)
    else $error("line driven outside frame");
  chk_oe_aligned:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      result_line_a_oe == result_line_b_oe &&
        result_line_a_oe == (!select_b && falls != 6'h20))
    else $error("line enables differ");
  chk_bits_hold:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      !select_b && sclk && $past(sclk) |->
        $stable(result_line_a) && $stable(result_line_b))
    else $error("line changed without a clock fall");
  chk_no_early_fall:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      $fell(select_b) |-> sclk ##1 sclk)
    else $error("clock fall at frame start");
  chk_lead_zeros:
    assert property (@(posedge sclk) disable iff (!rst_b || select_b)
      falls inside {1, 16, 17} |-> !result_line_a && !result_line_b)
    else $error("leading zero missing");
  chk_trail_zeros:
    assert property (@(posedge sclk) disable iff (!rst_b || select_b)
      falls inside {14, 15, 30, 31} |-> !result_line_a && !result_line_b)
    else $error("trailing zero missing");
  chk_release_32:
    assert property (@(posedge sclk) disable iff (!rst_b || select_b)
      falls == 6'h20 |-> !result_line_a_oe && !result_line_b_oe)
    else $error("line still driven after last fall");
endmodule

// file: bench/test_dual_adc_serial_readout.sv
/* Bench: host end and converter end joined by the link interface.
   Assumes package, interface, both ends and the checker compile first. */
`timescale 1ns/1ns
module test_dual_adc_serial_readout;
  typedef struct {
    logic [5:0]  len;
    logic [11:0] sa;
    logic [11:0] sb;
    logic [1:0]  mode;
  } row_t;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        req_valid = 1'b0;
  logic [5:0]  host_word_length = 6'h10;
  logic [11:0] sample_a = 12'h000;
  logic [11:0] sample_b = 12'h000;
  logic        req_ready;
  logic        resp_valid;
  logic        hold;
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic [1:0]  mode = 2'h0;
  int          n_errors = 0;
  int          n_checks = 0;
  row_t        rows [12];
  adc_link_pkg::power_mode_t power_mode;
  adc_link_if link ();
  always #5 sys_clk = ~sys_clk;
  adc_readout_host adc_readout_host_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_ready(req_ready),
    .host_word_length(host_word_length), .resp_valid(resp_valid),
    .word_a(word_a), .word_b(word_b), .link(link.host));
  adc_dual_readout_dev adc_dual_readout_dev_inst (.link(link.device),
    .rst_b(rst_b), .sample_a(sample_a), .sample_b(sample_b), .hold(hold),
    .power_mode(power_mode));
  adc_link_asserts adc_link_asserts_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .select_b(link.select_b), .sclk(link.sclk),
    .result_line_a_oe(link.result_line_a_oe),
    .result_line_b_oe(link.result_line_b_oe),
    .result_line_a(link.result_line_a), .result_line_b(link.result_line_b));
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_n(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic limit(input int c, input int lim);
    if (c >= lim) begin
      n_errors++;
      wrap_up();
    end
  endtask
  // bits in capture order, last captured bit at bit 0
  function automatic logic [31:0] exp_word(int n, logic [11:0] f,
                                           logic [11:0] s);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int k = 1; k <= n; k++) begin
      w = w << 1;
      if (k >= 2 && k <= 13) w[0] = f[13 - k];
      if (k >= 18 && k <= 29) w[0] = s[29 - k];
    end
    return w;
  endfunction
  task automatic start(input logic [5:0]  len,
                       input logic [11:0] sa,
                       input logic [11:0] sb);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    host_word_length <= len;
    sample_a <= sa;
    sample_b <= sb;
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  task automatic run(input row_t r);
    int          n;
    int          c;
    int          hc;
    logic [11:0] fa;
    logic [11:0] fb;
    n = (r.len == 6'h00 || r.len > 6'h20) ? 32 : int'(r.len);
    fa = (mode == 2'h0) ? r.sa : 12'h000;
    fb = (mode == 2'h0) ? r.sb : 12'h000;
    start(r.len, r.sa, r.sb);
    hc = 0;
    for (c = 0; resp_valid !== 1'b1; c++) begin
      limit(c, 300);
      @(posedge sys_clk);
      #1;
      if (hold === 1'b1) hc++;
    end
    cmp_n("answer cycle", 8 * n + 3, c);
    cmp_n("hold cycles", n >= 13 ? 103 : 8 * n + 2, hc);
    cmp("word a", exp_word(n, fa, fb), word_a);
    cmp("word b", exp_word(n, fb, fa), word_b);
    cmp("mode", {30'h0, r.mode}, {30'h0, power_mode});
    mode = r.mode;
    for (c = 0; req_ready !== 1'b1; c++) begin
      limit(c, 20);
      @(posedge sys_clk);
      #1;
    end
  endtask
  initial begin
    rows = '{'{6'h10, 12'ha5c, 12'h3f1, 2'h0}, '{6'h0e, 12'h800, 12'h001, 2'h0},
      '{6'h20, 12'hfff, 12'h555, 2'h0}, '{6'h28, 12'h9c3, 12'h0f0, 2'h0},
      '{6'h01, 12'h123, 12'h456, 2'h0}, '{6'h08, 12'h7e1, 12'h18f, 2'h1},
      '{6'h10, 12'h2d4, 12'h4b2, 2'h0}, '{6'h02, 12'h3a3, 12'h5c5, 2'h1},
      '{6'h09, 12'h111, 12'h222, 2'h2}, '{6'h0a, 12'h6b6, 12'h969, 2'h0},
      '{6'h10, 12'h0c0, 12'hf0f, 2'h0}, '{6'h08, 12'h3c3, 12'h2e2, 2'h1}};
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    // reset in the middle of a chained frame
    start(6'h20, sample_a, sample_b);
    repeat (60) @(posedge sys_clk);
    rst_b <= 1'b0;
    #2;
    cmp("select", 32'h1, {31'h0, link.select_b});
    cmp("line a oe", 32'h0, {31'h0, link.result_line_a_oe});
    cmp("mode", 32'h0, {30'h0, power_mode});
    cmp("word a", 32'h0, word_a);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    mode = 2'h0;
    run('{6'h10, 12'h5a5, 12'h1e1, 2'h0});
    wrap_up();
  end
endmodule
